// ===== core/dmact_pkg.sv
/*
 Constants, types and carriers shared by the cycle-timing and interrupt-vector block.
 Assumes a 200 MHz main clock and a synchronous, active-high reset.
*/
package dmact_pkg;

    localparam int NCH = 8;
    localparam int CH_W = 3;
    localparam int SZ_W = 16;
    localparam int VEC_W = 16;
    localparam int ADDR_W = 5;
    localparam int CNT_W = 11;

    // Global register group offset of the vector register
    localparam logic [ADDR_W-1:0] VEC_OFFSET = 5'h0e;
    localparam logic [VEC_W-1:0] VEC_RESET = 16'h0000;
    localparam logic [VEC_W-1:0] VEC_NONE = 16'h0000;

    // Timing
    localparam int CLK_PERIOD_PS = 5000;
    localparam int OSC_START_NS = 5000;
    localparam int OSC_START_CYC_I = (OSC_START_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam logic [CNT_W-1:0] OSC_START_CYC = CNT_W'(OSC_START_CYC_I);
    localparam logic [CNT_W-1:0] SYNC_FAST_CYC = 11'h001;
    localparam logic [CNT_W-1:0] SYNC_SLOW_CYC = 11'h002;
    localparam logic [CNT_W-1:0] MOVE_CYC = 11'h002;
    localparam logic [CNT_W-1:0] GAP_CYC = 11'h001;
    localparam logic [CNT_W-1:0] CNT_ONE = 11'h001;
    localparam logic [CNT_W-1:0] CNT_ZERO = 11'h000;
    localparam logic [SZ_W-1:0] SZ_ONE = 16'h0001;
    localparam logic [SZ_W-1:0] SZ_ZERO = 16'h0000;

    typedef enum logic [4:0] {
        ST_IDLE = 5'h01,
        ST_WAKE = 5'h02,
        ST_SYNC = 5'h04,
        ST_MOVE = 5'h08,
        ST_GAP = 5'h10
    } dmact_state_t;

    typedef enum logic [2:0] {
        PWR_ACTIVE = 3'h0,
        PWR_SLEEP_LEVEL_ZERO = 3'h1,
        PWR_SLEEP_LEVEL_ONE = 3'h2,
        PWR_SLEEP_LEVEL_THREE = 3'h3,
        PWR_SLEEP_LEVEL_FOUR = 3'h4
    } dmact_pwr_t;

    // Transfer request from the trigger and priority logic
    typedef struct packed {
        logic [CH_W-1:0] chan;
        logic block;
    } dmact_req_t;

    // Size counter load from software
    typedef struct packed {
        logic [CH_W-1:0] chan;
        logic [SZ_W-1:0] value;
    } dmact_szld_t;

endpackage

// ===== core/dmact_chan.sv
/*
 One channel: size counter and sticky completion flag.
 Assumes load, decrement and clear come from logic on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
module dmact_chan
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Control
    input wire logic load,
    input wire logic [dmact_pkg::SZ_W-1:0] load_val,
    input wire logic dec,
    input wire logic clr,
    // Status
    output logic flag,
    output logic zero
);

    logic [dmact_pkg::SZ_W-1:0] cnt_r;
    logic flag_r;

    ////////////////////////////////////////////////////////////////////////////
    // Size counter; a load overrides a decrement in the same cycle
    always_ff @(posedge clk)
    begin
        if (rst)
            cnt_r <= dmact_pkg::SZ_ZERO;
        else if (load)
            cnt_r <= load_val;
        else if (dec)
            cnt_r <= cnt_r - dmact_pkg::SZ_ONE;
    end

    // Flag sets on the step to zero; set beats a same-cycle clear
    always_ff @(posedge clk)
    begin
        if (rst)
            flag_r <= 1'b0;
        else if (dec && !load && cnt_r == dmact_pkg::SZ_ONE)
            flag_r <= 1'b1;
        else if (clr)
            flag_r <= 1'b0;
    end

    assign flag = flag_r;
    assign zero = (cnt_r == dmact_pkg::SZ_ZERO);

endmodule
`default_nettype wire

// ===== core/dmact_top.sv
/*
 Cycle timing, clock wake, interrupt interplay and the prioritised
 completion vector of a multi-channel transfer controller.
 Assumes requests come from trigger and priority logic on CLOCK, and that
 the NMI arrives asynchronously from a pin.
*/
`timescale 1ns/1ps
`default_nettype none
module dmact_top
(
    // Clock and reset
    input wire logic CLOCK,
    input wire logic RST,
    // Transfer request
    input wire logic XFER_REQ,
    input wire dmact_pkg::dmact_req_t XFER,
    output logic XFER_ACK,
    output logic XFER_BUSY,
    output logic MOVE_ACTIVE,
    output logic UNIT_DONE,
    output logic XFER_DONE,
    output logic [dmact_pkg::CH_W-1:0] ACTIVE_CHAN,
    // Size counter load
    input wire logic SZ_LOAD,
    input wire dmact_pkg::dmact_szld_t SZ_LD,
    // Power and clock system
    input wire dmact_pkg::dmact_pwr_t PWR_MODE,
    input wire logic CLK_IS_XTAL,
    input wire logic MCLK_STOPPED,
    output logic MCLK_RESTART,
    output logic CPU_HALT,
    // System interrupts
    input wire logic NMI_PIN,
    input wire logic NMI_ABORT_ENABLE,
    output logic IRQ_HOLD,
    output logic XFER_ABORTED,
    // Completion interrupt
    input wire logic [dmact_pkg::NCH-1:0] CHANNEL_IRQ_ENABLE,
    input wire logic GLOBAL_IRQ_ENABLE,
    input wire logic [dmact_pkg::NCH-1:0] FLAG_CLEAR,
    input wire logic [dmact_pkg::ADDR_W-1:0] GLB_ADDR,
    input wire logic GLB_RD,
    input wire logic GLB_WR,
    output logic [dmact_pkg::VEC_W-1:0] PENDING_CHANNEL_VECTOR,
    output logic [dmact_pkg::NCH-1:0] CHANNEL_DONE_FLAG,
    output logic DMA_IRQ
);

    dmact_pkg::dmact_state_t state_r;
    dmact_pkg::dmact_state_t state_nxt;
    logic [dmact_pkg::CNT_W-1:0] cnt_r;
    logic [dmact_pkg::CNT_W-1:0] cnt_nxt;
    logic [dmact_pkg::CH_W-1:0] chan_r;
    logic block_r;
    logic restart_r;
    logic nmi_q1_r;
    logic nmi_q2_r;
    logic nmi_q3_r;
    logic abort;
    logic take;
    logic cnt_last;
    logic deep_wait;
    logic [dmact_pkg::CNT_W-1:0] sync_len;
    logic [dmact_pkg::NCH-1:0] dec_vec;
    logic [dmact_pkg::NCH-1:0] clr_vec;
    logic [dmact_pkg::NCH-1:0] load_vec;
    logic [dmact_pkg::NCH-1:0] flags;
    logic [dmact_pkg::NCH-1:0] zeros;
    logic [dmact_pkg::NCH-1:0] pend;
    logic [dmact_pkg::NCH-1:0] top_bit;
    logic [dmact_pkg::VEC_W-1:0] vec_nxt;
    logic [dmact_pkg::VEC_W-1:0] vec_r;
    logic vec_access;
    logic irq_r;
    logic unit_done_r;
    logic done_r;
    logic aborted_r;

    ////////////////////////////////////////////////////////////////////////////
    // NMI pin synchroniser; the second and third stages feed the edge detector
    always_ff @(posedge CLOCK)
    begin
        if (RST)
        begin
            nmi_q1_r <= 1'b0;
            nmi_q2_r <= 1'b0;
            nmi_q3_r <= 1'b0;
        end
        else
        begin
            nmi_q1_r <= NMI_PIN;
            nmi_q2_r <= nmi_q1_r;
            nmi_q3_r <= nmi_q2_r;
        end
    end

    // Abort only while busy and only when enabled
    assign abort = nmi_q2_r && !nmi_q3_r && NMI_ABORT_ENABLE && state_r != dmact_pkg::ST_IDLE;

    ////////////////////////////////////////////////////////////////////////////
    // Timing selection
    // Any sleep level costs a second sync cycle: the clock tree is re-armed
    always_comb
    begin
        if (PWR_MODE == dmact_pkg::PWR_ACTIVE)
            sync_len = dmact_pkg::SYNC_FAST_CYC;
        else
            sync_len = dmact_pkg::SYNC_SLOW_CYC;
    end

    // Oscillator start-up wait applies only to the deep cases
    assign deep_wait = (PWR_MODE == dmact_pkg::PWR_SLEEP_LEVEL_FOUR)
        || (PWR_MODE == dmact_pkg::PWR_SLEEP_LEVEL_THREE && !CLK_IS_XTAL);

    assign take = XFER_REQ && state_r == dmact_pkg::ST_IDLE && !abort;
    assign cnt_last = (cnt_r == dmact_pkg::CNT_ONE);

    ////////////////////////////////////////////////////////////////////////////
    // Sequencer next state: wake, sync once per transfer, then move and gap
    always_comb
    begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        unique case (state_r)
            dmact_pkg::ST_IDLE:
            begin
                if (take)
                begin
                    if (MCLK_STOPPED && deep_wait)
                    begin
                        state_nxt = dmact_pkg::ST_WAKE;
                        cnt_nxt = dmact_pkg::OSC_START_CYC;
                    end
                    else
                    begin
                        state_nxt = dmact_pkg::ST_SYNC;
                        cnt_nxt = sync_len;
                    end
                end
            end
            dmact_pkg::ST_WAKE:
            begin
                cnt_nxt = cnt_r - dmact_pkg::CNT_ONE;
                if (cnt_last)
                begin
                    state_nxt = dmact_pkg::ST_SYNC;
                    cnt_nxt = sync_len;
                end
            end
            dmact_pkg::ST_SYNC:
            begin
                cnt_nxt = cnt_r - dmact_pkg::CNT_ONE;
                if (cnt_last)
                begin
                    state_nxt = dmact_pkg::ST_MOVE;
                    cnt_nxt = dmact_pkg::MOVE_CYC;
                end
            end
            dmact_pkg::ST_MOVE:
            begin
                cnt_nxt = cnt_r - dmact_pkg::CNT_ONE;
                if (cnt_last)
                begin
                    state_nxt = dmact_pkg::ST_GAP;
                    cnt_nxt = dmact_pkg::GAP_CYC;
                end
            end
            dmact_pkg::ST_GAP:
            begin
                cnt_nxt = cnt_r - dmact_pkg::CNT_ONE;
                if (cnt_last)
                begin
                    // A block repeats moves without a fresh sync
                    if (block_r && !zeros[chan_r])
                    begin
                        state_nxt = dmact_pkg::ST_MOVE;
                        cnt_nxt = dmact_pkg::MOVE_CYC;
                    end
                    else
                    begin
                        state_nxt = dmact_pkg::ST_IDLE;
                        cnt_nxt = dmact_pkg::CNT_ZERO;
                    end
                end
            end
        endcase
        if (abort)
        begin
            state_nxt = dmact_pkg::ST_IDLE;
            cnt_nxt = dmact_pkg::CNT_ZERO;
        end
    end

    // Sequencer state and counter
    always_ff @(posedge CLOCK)
    begin
        if (RST)
        begin
            state_r <= dmact_pkg::ST_IDLE;
            cnt_r <= dmact_pkg::CNT_ZERO;
        end
        else
        begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
        end
    end

    // Channel and mode captured at acceptance
    always_ff @(posedge CLOCK)
    begin
        if (RST)
        begin
            chan_r <= '0;
            block_r <= 1'b0;
        end
        else if (take)
        begin
            chan_r <= XFER.chan;
            block_r <= XFER.block;
        end
    end

    // Clock restart held for the whole transfer, dropped when idle again
    always_ff @(posedge CLOCK)
    begin
        if (RST)
            restart_r <= 1'b0;
        else if (take && MCLK_STOPPED)
            restart_r <= 1'b1;
        else if (state_nxt == dmact_pkg::ST_IDLE)
            restart_r <= 1'b0;
    end

    // Completion and abort pulses
    always_ff @(posedge CLOCK)
    begin
        if (RST)
        begin
            unit_done_r <= 1'b0;
            done_r <= 1'b0;
            aborted_r <= 1'b0;
        end
        else
        begin
            unit_done_r <= state_r == dmact_pkg::ST_MOVE && cnt_last && !abort;
            done_r <= state_r == dmact_pkg::ST_GAP && state_nxt == dmact_pkg::ST_IDLE && !abort;
            aborted_r <= abort;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Channels: counters decrement on the last move cycle of each unit
    always_comb
    begin
        dec_vec = '0;
        load_vec = '0;
        if (state_r == dmact_pkg::ST_MOVE && cnt_last && !abort)
            dec_vec[chan_r] = 1'b1;
        if (SZ_LOAD)
            load_vec[SZ_LD.chan] = 1'b1;
    end

    generate
        for (genvar i = 0; i < dmact_pkg::NCH; i++)
        begin : g_chan
            dmact_chan u_chan
            (
                .clk(CLOCK),
                .rst(RST),
                .load(load_vec[i]),
                .load_val(SZ_LD.value),
                .dec(dec_vec[i]),
                .clr(clr_vec[i]),
                .flag(flags[i]),
                .zero(zeros[i])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Vector: lowest-numbered enabled pending flag wins
    assign pend = flags & CHANNEL_IRQ_ENABLE;
    always_comb
    begin
        top_bit = '0;
        vec_nxt = dmact_pkg::VEC_NONE;
        for (int i = dmact_pkg::NCH - 1; i >= 0; i--)
        begin
            if (pend[i])
            begin
                top_bit = '0;
                top_bit[i] = 1'b1;
                vec_nxt = dmact_pkg::VEC_W'((i + 1) * 2);
            end
        end
    end

    // A read or a write at the vector offset counts as an access
    assign vec_access = (GLB_RD || GLB_WR) && GLB_ADDR == dmact_pkg::VEC_OFFSET;
    assign clr_vec = FLAG_CLEAR | (vec_access ? top_bit : '0);

    // Vector register and interrupt line, both registered
    always_ff @(posedge CLOCK)
    begin
        if (RST)
        begin
            vec_r <= dmact_pkg::VEC_RESET;
            irq_r <= 1'b0;
        end
        else
        begin
            vec_r <= vec_nxt;
            irq_r <= GLOBAL_IRQ_ENABLE && (|pend);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs
    assign XFER_ACK = take;
    assign XFER_BUSY = state_r != dmact_pkg::ST_IDLE;
    assign MOVE_ACTIVE = state_r == dmact_pkg::ST_MOVE;
    assign UNIT_DONE = unit_done_r;
    assign XFER_DONE = done_r;
    assign XFER_ABORTED = aborted_r;
    assign ACTIVE_CHAN = chan_r;
    assign MCLK_RESTART = restart_r;
    // Halt regardless of handler context; the CPU is never woken here
    assign CPU_HALT = state_r != dmact_pkg::ST_IDLE;
    // Maskable requests wait until the sequencer is idle
    assign IRQ_HOLD = state_r != dmact_pkg::ST_IDLE;
    assign PENDING_CHANNEL_VECTOR = vec_r;
    assign CHANNEL_DONE_FLAG = flags;
    assign DMA_IRQ = irq_r;

endmodule
`default_nettype wire

// ===== core/dmact_top_guard_unused.sv
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// ===== tb/dmact_assertions.sv
/*
 Checker for the transfer timing and completion vector block.
 Bound to the top module; sees its ports only.
*/
`timescale 1ns/1ps
`default_nettype none
module dmact_assertions
(
    // Clock and reset
    input wire logic CLOCK,
    input wire logic RST,
    // Transfer
    input wire dmact_pkg::dmact_req_t XFER,
    input wire logic XFER_ACK,
    input wire logic XFER_BUSY,
    input wire logic MOVE_ACTIVE,
    input wire logic UNIT_DONE,
    input wire logic XFER_DONE,
    input wire logic XFER_ABORTED,
    input wire logic NMI_ABORT_ENABLE,
    // Power
    input wire dmact_pkg::dmact_pwr_t PWR_MODE,
    input wire logic CLK_IS_XTAL,
    input wire logic MCLK_STOPPED,
    input wire logic MCLK_RESTART,
    input wire logic CPU_HALT,
    input wire logic IRQ_HOLD,
    // Vector
    input wire logic [7:0] CHANNEL_IRQ_ENABLE,
    input wire logic GLOBAL_IRQ_ENABLE,
    input wire logic [4:0] GLB_ADDR,
    input wire logic GLB_RD,
    input wire logic GLB_WR,
    input wire logic [15:0] PENDING_CHANNEL_VECTOR,
    input wire logic [7:0] CHANNEL_DONE_FLAG,
    input wire logic DMA_IRQ
);
    default clocking @(posedge CLOCK); endclocking
    default disable iff (RST);

    // Enabled pending flags, vector access and the plain fast case
    wire logic [7:0] pend = CHANNEL_DONE_FLAG & CHANNEL_IRQ_ENABLE;
    wire logic acc = (GLB_RD | GLB_WR) && GLB_ADDR == dmact_pkg::VEC_OFFSET;
    wire logic fast = PWR_MODE == dmact_pkg::PWR_ACTIVE && !MCLK_STOPPED;
    // Sleep cases that need no oscillator start-up
    wire logic light = PWR_MODE != dmact_pkg::PWR_ACTIVE && !(MCLK_STOPPED
        && (PWR_MODE == dmact_pkg::PWR_SLEEP_LEVEL_FOUR
        || (PWR_MODE == dmact_pkg::PWR_SLEEP_LEVEL_THREE && !CLK_IS_XTAL)));

    // Channel 0 must win, so scan from the top down
    function automatic logic [15:0] enc(input logic [7:0] p);
        logic [15:0] v;
        v = 16'h0000;
        for (int i = 7; i >= 0; i--)
            if (p[i]) v = 16'(2 * i + 2);
        return v;
    endfunction

    ////////////////////////////////////////////////////////////////
    move_timing_a: assert property (XFER_ACK && fast |=>
        !MOVE_ACTIVE ##1 MOVE_ACTIVE [*2] ##1 !MOVE_ACTIVE) else $error("move phase timing wrong");
    single_time_a: assert property (XFER_ACK && fast && !XFER.block |-> ##4 UNIT_DONE)
        else $error("single transfer late");
    sleep_time_a: assert property (XFER_ACK && light && !XFER.block |-> ##5 UNIT_DONE)
        else $error("sleep transfer late");
    end_kind_a: assert property ((XFER_DONE || XFER_ABORTED) == $fell(XFER_BUSY)
        && !(XFER_DONE && XFER_ABORTED)) else $error("transfer end pulse wrong");
    abort_gate_a: assert property (XFER_ABORTED |-> $past(NMI_ABORT_ENABLE))
        else $error("abort without enable");
    busy_halt_a: assert property (CPU_HALT == XFER_BUSY && IRQ_HOLD == XFER_BUSY)
        else $error("halt or hold differs from busy");
    wake_req_a: assert property (XFER_ACK && MCLK_STOPPED |=> MCLK_RESTART && XFER_BUSY)
        else $error("clock not restarted");
    wake_off_a: assert property ($fell(XFER_BUSY) |-> ##[0:1] !MCLK_RESTART)
        else $error("clock left running");
    vec_mirror_a: assert property (!$past(RST) |-> PENDING_CHANNEL_VECTOR == enc($past(pend)))
        else $error("vector value wrong");
    irq_mirror_a: assert property (!$past(RST) |-> DMA_IRQ == $past(GLOBAL_IRQ_ENABLE && pend != 8'h00))
        else $error("irq request wrong");
    vec_clear_a: assert property (acc |=> (CHANNEL_DONE_FLAG & $past(pend & (~pend + 8'h01))) == 8'h00)
        else $error("access did not clear top flag");

    // Main scenarios
    cover property (XFER_ACK && MCLK_STOPPED);
    cover property (XFER_ACK && XFER.block);
    cover property (acc && pend != 8'h00);
endmodule

bind dmact_top dmact_assertions chk_u (.CLOCK(CLOCK), .RST(RST), .XFER(XFER), .XFER_ACK(XFER_ACK),
    .XFER_BUSY(XFER_BUSY), .MOVE_ACTIVE(MOVE_ACTIVE), .UNIT_DONE(UNIT_DONE), .PWR_MODE(PWR_MODE),
    .XFER_DONE(XFER_DONE), .XFER_ABORTED(XFER_ABORTED), .NMI_ABORT_ENABLE(NMI_ABORT_ENABLE),
    .CLK_IS_XTAL(CLK_IS_XTAL),
    .MCLK_STOPPED(MCLK_STOPPED), .MCLK_RESTART(MCLK_RESTART), .CPU_HALT(CPU_HALT),
    .IRQ_HOLD(IRQ_HOLD), .CHANNEL_IRQ_ENABLE(CHANNEL_IRQ_ENABLE),
    .GLOBAL_IRQ_ENABLE(GLOBAL_IRQ_ENABLE), .GLB_ADDR(GLB_ADDR), .GLB_RD(GLB_RD), .GLB_WR(GLB_WR),
    .PENDING_CHANNEL_VECTOR(PENDING_CHANNEL_VECTOR), .CHANNEL_DONE_FLAG(CHANNEL_DONE_FLAG),
    .DMA_IRQ(DMA_IRQ));
`default_nettype wire

// ===== tb/dmact_partner.sv
/*
 Trigger sources on the far side: raises a transfer request and holds it.
 Assumes the bench pulses one of the two serial bus triggers for one cycle.
*/
`timescale 1ns/1ps
`default_nettype none
module dmact_partner
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Serial bus triggers from the bench: bit 0 receive ready, bit 1 transmit needed
    input wire logic [1:0] trig,
    input wire dmact_pkg::dmact_req_t want,
    // Request side
    input wire logic ack,
    output logic req,
    output dmact_pkg::dmact_req_t xfer
);
    // Held until taken, whatever the processor is doing
    always_ff @(posedge clk)
    begin
        if (rst)
            req <= 1'b0;
        else if (|trig)
            req <= 1'b1;
        else if (ack)
            req <= 1'b0;
    end

    // Released lines flip so a stale channel is never read as valid
    always_ff @(posedge clk)
    begin
        if (|trig)
            xfer <= want;
        else if (ack)
            xfer <= ~xfer;
    end
endmodule
`default_nettype wire

// ===== tb/dmact_top_tb.sv
/*
 Self-checking bench for the transfer timing and completion vector block.
 Drives on the rising edge, samples on the falling edge.
*/
`timescale 1ns/1ps
`default_nettype none
module dmact_top_tb;
    logic CLOCK, RST, XFER_REQ, XFER_ACK, XFER_BUSY, MOVE_ACTIVE, UNIT_DONE, XFER_DONE;
    logic [1:0] trig;
    logic [7:0] FLAG_CLEAR;
    logic SZ_LOAD, CLK_IS_XTAL, MCLK_STOPPED, MCLK_RESTART, CPU_HALT, NMI_PIN, IRQ_HOLD;
    logic NMI_ABORT_ENABLE, XFER_ABORTED, GLOBAL_IRQ_ENABLE, GLB_RD, GLB_WR, DMA_IRQ;
    logic [2:0] ACTIVE_CHAN;
    logic [4:0] GLB_ADDR;
    logic [7:0] CHANNEL_IRQ_ENABLE, CHANNEL_DONE_FLAG;
    logic [15:0] PENDING_CHANNEL_VECTOR;
    dmact_pkg::dmact_req_t want, XFER;
    dmact_pkg::dmact_szld_t SZ_LD;
    dmact_pkg::dmact_pwr_t PWR_MODE;
    int miscompares, checks, n;
    // Mode, crystal, stopped clock and cycles for channels 1 to 6
    int md [6] = '{0, 1, 2, 3, 3, 4};
    int ex [6] = '{5, 6, 6, 6, 1006, 1006};
    logic [5:0] xt = 6'h2d;
    logic [5:0] st = 6'h38;

    dmact_top dut_u (.CLOCK, .RST, .XFER_REQ, .XFER, .XFER_ACK, .XFER_BUSY, .MOVE_ACTIVE,
        .UNIT_DONE, .XFER_DONE, .ACTIVE_CHAN, .SZ_LOAD, .SZ_LD, .PWR_MODE, .CLK_IS_XTAL,
        .MCLK_STOPPED, .MCLK_RESTART, .CPU_HALT, .NMI_PIN, .NMI_ABORT_ENABLE, .IRQ_HOLD,
        .XFER_ABORTED, .CHANNEL_IRQ_ENABLE, .GLOBAL_IRQ_ENABLE, .FLAG_CLEAR, .GLB_ADDR,
        .GLB_RD, .GLB_WR, .PENDING_CHANNEL_VECTOR, .CHANNEL_DONE_FLAG, .DMA_IRQ);
    dmact_partner req_u (.clk(CLOCK), .rst(RST), .trig, .want, .ack(XFER_ACK), .req(XFER_REQ),
        .xfer(XFER));

    // 200 MHz main clock
    initial
    begin
        CLOCK = 1'b0;
        forever #2.5 CLOCK = ~CLOCK;
    end

    ////////////////////////////////////////////////////////////////
    task automatic end_of_test;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        checks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    // A wait that ran out ends the run
    task automatic lapse(input int lim);
        if (n >= lim)
        begin
            miscompares++;
            $display("BAD wait expected event seen timeout");
            end_of_test();
        end
    endtask

    // Load the size counter and trigger, then wait for the ack
    task automatic start(input logic [2:0] ch, input logic blk, input logic [15:0] sz);
        @(posedge CLOCK);
        trig <= ch[0] ? 2'h2 : 2'h1;
        want <= '{ch, blk};
        SZ_LOAD <= 1'b1;
        SZ_LD <= '{ch, sz};
        @(posedge CLOCK);
        trig <= 2'h0;
        SZ_LOAD <= 1'b0;
        n = 0;
        do
        begin
            @(negedge CLOCK);
            n++;
        end
        while (XFER_ACK !== 1'b1 && n < 20);
        lapse(20);
    endtask

    // Count cycles from the ack to the done pulse
    task automatic await_done(input int exp);
        n = 0;
        do
        begin
            @(negedge CLOCK);
            n++;
        end
        while (XFER_DONE !== 1'b1 && n < 1100);
        lapse(1100);
        chk("cycles", 16'(exp), 16'(n));
    endtask

    // One-cycle strobe on the global register group
    task automatic access(input logic [4:0] a, input logic wr);
        @(posedge CLOCK);
        GLB_ADDR <= a;
        GLB_RD <= !wr;
        GLB_WR <= wr;
        @(posedge CLOCK);
        GLB_RD <= 1'b0;
        GLB_WR <= 1'b0;
    endtask

    // NMI held past the three-stage synchroniser
    task automatic nmi;
        @(posedge CLOCK);
        NMI_PIN <= 1'b1;
        repeat (3) @(posedge CLOCK);
        NMI_PIN <= 1'b0;
        repeat (5) @(negedge CLOCK);
    endtask

    ////////////////////////////////////////////////////////////////
    initial
    begin
        RST = 1'b1;
        {trig, SZ_LOAD, CLK_IS_XTAL, MCLK_STOPPED, NMI_PIN, NMI_ABORT_ENABLE} = '0;
        {GLOBAL_IRQ_ENABLE, GLB_RD, GLB_WR, GLB_ADDR, CHANNEL_IRQ_ENABLE} = '0;
        want = '0;
        FLAG_CLEAR = '0;
        SZ_LD = '0;
        PWR_MODE = dmact_pkg::PWR_ACTIVE;
        miscompares = 0;
        checks = 0;
        repeat (5) @(posedge CLOCK);
        RST <= 1'b0;
        @(negedge CLOCK);
        chk("vector", 16'h0000, PENDING_CHANNEL_VECTOR);
        start(3'h0, 1'b0, 16'h0001);
        await_done(5);
        for (int i = 0; i < 6; i++)
        begin
            @(posedge CLOCK);
            PWR_MODE <= dmact_pkg::dmact_pwr_t'(md[i]);
            CLK_IS_XTAL <= xt[i];
            MCLK_STOPPED <= st[i];
            start(3'(i + 1), 1'b0, 16'h0001);
            await_done(ex[i]);
        end
        @(posedge CLOCK);
        PWR_MODE <= dmact_pkg::PWR_ACTIVE;
        MCLK_STOPPED <= 1'b0;
        start(3'h7, 1'b1, 16'h0003);
        await_done(11);
        chk("flags", 16'h00ff, {8'h00, CHANNEL_DONE_FLAG});
        chk("chan", 16'h0007, {13'h0000, ACTIVE_CHAN});
        $display("test timing done");
        @(posedge CLOCK);
        CHANNEL_IRQ_ENABLE <= 8'hfe;
        repeat (3) @(negedge CLOCK);
        chk("vector", 16'h0004, PENDING_CHANNEL_VECTOR);
        chk("irq", 16'h0000, {15'h0000, DMA_IRQ});
        @(posedge CLOCK);
        CHANNEL_IRQ_ENABLE <= 8'hff;
        GLOBAL_IRQ_ENABLE <= 1'b1;
        access(5'h0c, 1'b0);
        for (int k = 0; k < 8; k++)
        begin
            repeat (3) @(negedge CLOCK);
            chk("vector", 16'(2 * k + 2), PENDING_CHANNEL_VECTOR);
            chk("irq", 16'h0001, {15'h0000, DMA_IRQ});
            access(5'h0e, k[0]);
        end
        repeat (3) @(negedge CLOCK);
        chk("vector", 16'h0000, PENDING_CHANNEL_VECTOR);
        chk("irq", 16'h0000, {15'h0000, DMA_IRQ});
        $display("test vector done");
        // Sticky flag, then a software clear
        start(3'h2, 1'b0, 16'h0001);
        await_done(5);
        repeat (4) @(negedge CLOCK);
        chk("flags", 16'h0004, {8'h00, CHANNEL_DONE_FLAG});
        chk("vector", 16'h0006, PENDING_CHANNEL_VECTOR);
        @(posedge CLOCK);
        FLAG_CLEAR <= 8'h04;
        @(posedge CLOCK);
        FLAG_CLEAR <= 8'h00;
        @(negedge CLOCK);
        chk("flags", 16'h0000, {8'h00, CHANNEL_DONE_FLAG});
        $display("test clear done");
        @(posedge CLOCK);
        PWR_MODE <= dmact_pkg::PWR_SLEEP_LEVEL_FOUR;
        MCLK_STOPPED <= 1'b1;
        start(3'h0, 1'b0, 16'h0001);
        nmi();
        chk("busy", 16'h0001, {15'h0000, XFER_BUSY});
        chk("hold", 16'h0003, {14'h0000, CPU_HALT, IRQ_HOLD});
        @(posedge CLOCK);
        NMI_ABORT_ENABLE <= 1'b1;
        nmi();
        chk("busy", 16'h0000, {15'h0000, XFER_BUSY});
        chk("flags", 16'h0000, {8'h00, CHANNEL_DONE_FLAG});
        $display("test abort done");
        end_of_test();
    end
endmodule
`default_nettype wire
